// *** rtl/armature_current_loop.v ***
// Purpose: armature current loop settings and firing supervision
// Assumes: demand, feedback, speed and reference share the system clock
// Notes: partner conduction arrives on a pin and is synchronised
//
// Notes on behaviour
// - proportional gain 0..255, reset 16, over 256
// - integral gain 0..255, reset 16, over 512
// - continuous autotune never writes integral gain
// - motor constant, reset 50, scales discontinuous prediction
// - start-up autotune writes motor constant and gains
// - inhibit stops both bridges, resets ramps
// - standstill phases back below 0.8%, then stops
// - trigger select: stop or zero, stop only
// - direct mode: angle from post-ramp reference
// - direct mode keeps overcurrent trip and standstill stop
// - lockout: no bridge change while partner conducts
// - adaptive control uses high gain when discontinuous
// - series twelve drives normal and delayed pulses
// - series twelve refused while bridge-2 quadrants on
// - firing angle spans 277 to 1023
//
// Implementation choices: the placing of the registers and register access over APB.
`include "current_loop_defs.vh"
`timescale 1ns/1ps
module armature_current_loop #(
  parameter STANDSTILL_DELAY = `STANDSTILL_DELAY_CYC
) (
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  input wire signed [10:0] DEMAND_I,
  input wire signed [10:0] FEEDBACK_I,
  input wire signed [10:0] SPEED_I,
  input wire signed [10:0] RAMP_REF_I,
  input wire STOP_I,
  input wire DISCONT_I,
  input wire OVERCURRENT_I,
  input wire BRIDGE_REQ_I,
  input wire [1:0] BRIDGE2_QUAD_I,
  input wire PARTNER_CONDUCTING_I,
  input wire TUNE_LOAD_I,
  input wire [7:0] TUNE_PROP_I,
  input wire [7:0] TUNE_INT_I,
  input wire [7:0] TUNE_MC_I,
  input wire CTUNE_LOAD_I,
  input wire [7:0] CTUNE_PROP_I,
  output reg [9:0] FIRING_ANGLE_O,
  output reg FIRE_EN_O,
  output reg DELAYED_FIRE_EN_O,
  output reg RAMP_RESET_O,
  output reg BRIDGE_SEL_O,
  output reg CONDUCTING_O
);

  // --------------------------------------------------------------------
  // state codes
  // --------------------------------------------------------------------
  localparam SS_IDLE = 2'b00;
  localparam SS_PHASE = 2'b01;
  localparam SS_STOP = 2'b10;

  reg [7:0] prop_gain_reg;
  reg [7:0] int_gain_reg;
  reg [7:0] motor_const_reg;
  reg [6:0] control_reg;
  reg trip_reg;
  reg [1:0] ss_state_reg;
  reg [1:0] ss_state_next;
  reg [31:0] ss_count_reg;
  reg signed [19:0] integ_reg;
  reg signed [19:0] integ_next;
  reg [9:0] angle_next;
  reg [31:0] rdata_next;
  reg ss_active;
  wire partner_sync;
  wire apb_write;
  wire apb_read;
  wire signed [11:0] error;
  wire signed [11:0] demand_x;
  wire signed [20:0] p_term;
  wire signed [20:0] i_term;
  wire signed [20:0] mc_term;
  wire [10:0] speed_abs;
  wire speed_low;
  wire zero_ref;
  wire ss_engage;
  wire adaptive_on;
  wire fire_allowed;
  wire ctl_suppress;
  wire ctl_direct;
  wire ctl_sq12;

  assign ctl_suppress = control_reg[`CTL_SUPPRESS];
  assign ctl_direct = control_reg[`CTL_DIRECT];
  assign ctl_sq12 = control_reg[`CTL_SQ12];

  // --------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------
  assign apb_write = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  assign apb_read = PSEL_I & PENABLE_I & ~PREADY_O & ~PWRITE_I;

  always @* begin
    rdata_next = 32'h00000000;
    case (PADDR_I)
      `OFS_PROP_GAIN: rdata_next = {24'h000000, prop_gain_reg};
      `OFS_INT_GAIN: rdata_next = {24'h000000, int_gain_reg};
      `OFS_MOTOR_CONST: rdata_next = {24'h000000, motor_const_reg};
      `OFS_RESERVED: rdata_next = 32'h00000000;
      `OFS_CONTROL: rdata_next = {25'h0000000, control_reg};
      `OFS_STATUS: begin
        rdata_next[`STS_TRIP] = trip_reg;
        rdata_next[`STS_STANDSTILL] = ss_active;
        rdata_next[`STS_FIRING] = FIRE_EN_O;
        rdata_next[`STS_PHASED_BACK] = (FIRING_ANGLE_O == `ANGLE_MIN);
      end
      `OFS_ANGLE: rdata_next = {22'h000000, FIRING_ANGLE_O};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
      PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & (PADDR_I > `OFS_ANGLE);
      if (apb_read) begin
        PRDATA_O <= rdata_next;
      end
    end
  end

  // --------------------------------------------------------------------
  // settings registers
  // --------------------------------------------------------------------
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prop_gain_reg <= `RST_PROP_GAIN;
      int_gain_reg <= `RST_INT_GAIN;
      motor_const_reg <= `RST_MOTOR_CONST;
      control_reg <= `RST_CONTROL;
    end else begin
      if (apb_write && PADDR_I == `OFS_PROP_GAIN) begin
        prop_gain_reg <= PWDATA_I[7:0];
      end
      if (apb_write && PADDR_I == `OFS_INT_GAIN) begin
        int_gain_reg <= PWDATA_I[7:0];
      end
      if (apb_write && PADDR_I == `OFS_MOTOR_CONST) begin
        motor_const_reg <= PWDATA_I[7:0];
      end
      if (apb_write && PADDR_I == `OFS_CONTROL) begin
        control_reg <= PWDATA_I[6:0];
        if (BRIDGE2_QUAD_I != 2'b00) begin
          control_reg[`CTL_SQ12] <= 1'b0;
        end
      end
      if (CTUNE_LOAD_I) begin
        prop_gain_reg <= CTUNE_PROP_I;
      end
      if (TUNE_LOAD_I) begin
        prop_gain_reg <= TUNE_PROP_I;
        int_gain_reg <= TUNE_INT_I;
        motor_const_reg <= TUNE_MC_I;
      end
    end
  end

  // --------------------------------------------------------------------
  // overcurrent trip, set wins over clear
  // --------------------------------------------------------------------
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      trip_reg <= 1'b0;
    end else if (OVERCURRENT_I) begin
      trip_reg <= 1'b1;
    end else if (apb_write && PADDR_I == `OFS_STATUS &&
                 PWDATA_I[`STS_TRIP]) begin
      trip_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // standstill detection
  // --------------------------------------------------------------------
  assign speed_abs = SPEED_I[10] ? (~SPEED_I + 11'd1) : SPEED_I;
  assign speed_low = ({21'd0, speed_abs} * 32'd1000) <
                     (`SPEED_FULL * `SS_PER_MILLE);
  assign zero_ref = (RAMP_REF_I == 11'sd0);
  assign ss_engage = control_reg[`CTL_SS_ENABLE] & speed_low &
                     (STOP_I | (~control_reg[`CTL_SS_TRIGGER] & zero_ref));

  always @* begin
    ss_state_next = ss_state_reg;
    case (ss_state_reg)
      SS_IDLE: begin
        if (ss_engage) begin
          ss_state_next = SS_PHASE;
        end
      end
      SS_PHASE: begin
        if (!ss_engage) begin
          ss_state_next = SS_IDLE;
        end else if (ss_count_reg >= STANDSTILL_DELAY - 1) begin
          ss_state_next = SS_STOP;
        end
      end
      SS_STOP: begin
        if (!ss_engage) begin
          ss_state_next = SS_IDLE;
        end
      end
      default: ss_state_next = SS_IDLE;
    endcase
    ss_active = (ss_state_reg != SS_IDLE);
  end

  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ss_state_reg <= SS_IDLE;
      ss_count_reg <= 32'h00000000;
    end else begin
      ss_state_reg <= ss_state_next;
      if (ss_state_reg == SS_PHASE && ss_state_next == SS_PHASE) begin
        ss_count_reg <= ss_count_reg + 32'd1;
      end else begin
        ss_count_reg <= 32'h00000000;
      end
    end
  end

  // --------------------------------------------------------------------
  // current loop arithmetic
  // --------------------------------------------------------------------
  assign error = {DEMAND_I[10], DEMAND_I} - {FEEDBACK_I[10], FEEDBACK_I};
  assign demand_x = {DEMAND_I[10], DEMAND_I};

  assign adaptive_on = ~control_reg[`CTL_ADAPT_DIS] & DISCONT_I;

  gain_scale #(
    .IN_W(12),
    .SHIFT(`PROP_SHIFT)
  ) u_prop (
    .clk(SYS_CLK_I),
    .rst(RST_I),
    .value(error),
    .gain(prop_gain_reg),
    .scaled(p_term)
  );

  gain_scale #(
    .IN_W(12),
    .SHIFT(`INT_SHIFT)
  ) u_int (
    .clk(SYS_CLK_I),
    .rst(RST_I),
    .value(error),
    .gain(int_gain_reg),
    .scaled(i_term)
  );

  gain_scale #(
    .IN_W(12),
    .SHIFT(`MC_SHIFT)
  ) u_mc (
    .clk(SYS_CLK_I),
    .rst(RST_I),
    .value(demand_x),
    .gain(motor_const_reg),
    .scaled(mc_term)
  );

  function [9:0] clamp_angle;
    input signed [21:0] v;
    begin
      if (v < $signed({12'd0, `ANGLE_MIN})) begin
        clamp_angle = `ANGLE_MIN;
      end else if (v > $signed({12'd0, `ANGLE_MAX})) begin
        clamp_angle = `ANGLE_MAX;
      end else begin
        clamp_angle = v[9:0];
      end
    end
  endfunction

  assign fire_allowed = ~ctl_suppress & ~trip_reg & (ss_state_reg != SS_STOP);

  always @* begin
    integ_next = integ_reg + i_term[19:0];
    if (integ_next > 20'sd200000) begin
      integ_next = 20'sd200000;
    end else if (integ_next < -20'sd200000) begin
      integ_next = -20'sd200000;
    end
    if (!fire_allowed || ss_active || ctl_direct) begin
      integ_next = 20'sd0;
    end
    if (ss_active) begin
      angle_next = `ANGLE_MIN;
    end else if (ctl_direct) begin
      angle_next = clamp_angle({{11{RAMP_REF_I[10]}}, RAMP_REF_I} +
                               $signed({12'd0, `ANGLE_MIN}));
    end else if (adaptive_on) begin
      angle_next = clamp_angle($signed({12'd0, `ANGLE_MIN}) +
                               {mc_term[20], mc_term} +
                               {p_term[20], p_term} + {p_term[20], p_term});
    end else begin
      angle_next = clamp_angle($signed({12'd0, `ANGLE_MID}) +
                               {p_term[20], p_term} +
                               {{2{integ_reg[19]}}, integ_reg});
    end
  end

  // --------------------------------------------------------------------
  // bridge lockout
  // --------------------------------------------------------------------
  pin_sync3 u_partner (
    .clk(SYS_CLK_I),
    .rst(RST_I),
    .din(PARTNER_CONDUCTING_I),
    .dout(partner_sync)
  );

  // --------------------------------------------------------------------
  // firing outputs
  // --------------------------------------------------------------------
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      integ_reg <= 20'sd0;
      FIRING_ANGLE_O <= `ANGLE_MIN;
      FIRE_EN_O <= 1'b0;
      DELAYED_FIRE_EN_O <= 1'b0;
      RAMP_RESET_O <= 1'b0;
      BRIDGE_SEL_O <= 1'b0;
      CONDUCTING_O <= 1'b0;
    end else begin
      integ_reg <= integ_next;
      FIRING_ANGLE_O <= angle_next;
      FIRE_EN_O <= fire_allowed;
      DELAYED_FIRE_EN_O <= fire_allowed & ctl_sq12;
      RAMP_RESET_O <= ctl_suppress;
      CONDUCTING_O <= fire_allowed;
      if (!(control_reg[`CTL_LOCKOUT] && partner_sync)) begin
        BRIDGE_SEL_O <= BRIDGE_REQ_I;
      end
    end
  end

endmodule

// *** rtl/current_loop_defs.vh ***
// Purpose: constants for the armature current loop and firing control
// Assumes: 10 MHz system clock, APB byte addressing
// Notes: offsets are byte addresses on the APB bus
`ifndef CURRENT_LOOP_DEFS_VH
`define CURRENT_LOOP_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_PROP_GAIN 8'h00
`define OFS_INT_GAIN 8'h04
`define OFS_MOTOR_CONST 8'h08
`define OFS_RESERVED 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_STATUS 8'h14
`define OFS_ANGLE 8'h18

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_PROP_GAIN 8'h10
`define RST_INT_GAIN 8'h10
`define RST_MOTOR_CONST 8'h32
`define RST_CONTROL 7'h02

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTL_SUPPRESS 0
`define CTL_SS_ENABLE 1
`define CTL_SS_TRIGGER 2
`define CTL_DIRECT 3
`define CTL_LOCKOUT 4
`define CTL_ADAPT_DIS 5
`define CTL_SQ12 6

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define STS_TRIP 0
`define STS_STANDSTILL 1
`define STS_FIRING 2
`define STS_PHASED_BACK 3

// ----------------------------------------------------------------------
// gain scaling and firing angle limits
// ----------------------------------------------------------------------
`define PROP_SHIFT 8
`define INT_SHIFT 9
`define MC_SHIFT 6
`define ANGLE_MIN 10'd277
`define ANGLE_MAX 10'd1023
`define ANGLE_MID 10'd650

// ----------------------------------------------------------------------
// standstill timing and threshold
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ 10000000
`define STANDSTILL_DELAY_US 10000
`define STANDSTILL_DELAY_CYC (`STANDSTILL_DELAY_US * (`CLK_FREQ_HZ / 1000000))
`define SPEED_FULL 1000
`define SS_PER_MILLE 8

`endif

// *** rtl/gain_scale.v ***
// Purpose: registered signed value times unsigned gain, shifted down
// Assumes: gain is an unsigned 8-bit setting
// Notes: arithmetic shift keeps the sign
`timescale 1ns/1ps
module gain_scale #(
  parameter IN_W = 12,
  parameter SHIFT = 8
) (
  input wire clk,
  input wire rst,
  input wire signed [IN_W-1:0] value,
  input wire [7:0] gain,
  output reg signed [IN_W+8:0] scaled
);

  wire signed [IN_W+8:0] product;

  assign product = value * $signed({1'b0, gain});

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scaled <= {(IN_W+9){1'b0}};
    end else begin
      scaled <= product >>> SHIFT;
    end
  end

endmodule

// *** rtl/pin_sync3.v ***
// Purpose: three-stage synchroniser for a pin input
// Assumes: input asynchronous to the clock
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end

endmodule

// *** verification/armature_current_loop_sva.sv ***
// Purpose: port checker for the armature current loop block
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to the top module below
`timescale 1ns/1ps
module armature_current_loop_sva #(
  parameter STANDSTILL_DELAY = 8
) (
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire OVERCURRENT_I,
  input wire BRIDGE_REQ_I,
  input wire PARTNER_CONDUCTING_I,
  input wire [31:0] PRDATA_O,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire [9:0] FIRING_ANGLE_O,
  input wire FIRE_EN_O,
  input wire RAMP_RESET_O,
  input wire BRIDGE_SEL_O,
  input wire CONDUCTING_O
);
  // --------------------
  // helpers and properties
  // --------------------
  reg [2:0] oc_hist;
  wire angle_min = FIRING_ANGLE_O == 10'h115;
  always @(posedge SYS_CLK_I or posedge RST_I)
    if (RST_I)
      oc_hist <= 3'h0;
    else
      oc_hist <= {oc_hist[1:0], OVERCURRENT_I};
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_access;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  sequence s_stop_fall;
    $fell(FIRE_EN_O) && !RAMP_RESET_O && !OVERCURRENT_I && oc_hist == 3'h0;
  endsequence
  sequence s_req_quiet;
    ($stable(BRIDGE_REQ_I) && !PARTNER_CONDUCTING_I)[*6];
  endsequence
  property p_angle_range;
    FIRING_ANGLE_O >= 10'h115;
  endproperty
  property p_inhibit;
    RAMP_RESET_O |-> ##[0:1] !FIRE_EN_O;
  endproperty
  property p_conduct;
    CONDUCTING_O == FIRE_EN_O;
  endproperty
  property p_answer;
    s_access |=> PREADY_O;
  endproperty
  property p_pulse;
    PREADY_O |=> !PREADY_O;
  endproperty
  property p_slverr;
    PREADY_O |-> PSLVERR_O == (PADDR_I > 8'h18);
  endproperty
  property p_err_data;
    PREADY_O && PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0;
  endproperty
  property p_phase_back;
    s_stop_fall |-> $past(angle_min, 4);
  endproperty
  property p_bridge;
    s_req_quiet |-> BRIDGE_SEL_O == BRIDGE_REQ_I;
  endproperty
  a_angle_range: assert property (p_angle_range)
    else $error("firing angle below minimum");
  a_inhibit: assert property (p_inhibit)
    else $error("firing while ramps held in reset");
  a_conduct: assert property (p_conduct)
    else $error("conducting output differs from fire enable");
  a_answer: assert property (p_answer)
    else $error("no ready one cycle after access");
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  a_slverr: assert property (p_slverr)
    else $error("error response wrong for address");
  a_err_data: assert property (p_err_data)
    else $error("unmapped read data not zero");
  a_phase_back: assert property (p_phase_back)
    else $error("firing stopped without phase back");
  a_bridge: assert property (p_bridge)
    else $error("bridge select not following request");
endmodule
bind armature_current_loop armature_current_loop_sva #(
  .STANDSTILL_DELAY(STANDSTILL_DELAY)
) u_sva (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .OVERCURRENT_I(OVERCURRENT_I), .BRIDGE_REQ_I(BRIDGE_REQ_I),
  .PARTNER_CONDUCTING_I(PARTNER_CONDUCTING_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .FIRING_ANGLE_O(FIRING_ANGLE_O), .FIRE_EN_O(FIRE_EN_O),
  .RAMP_RESET_O(RAMP_RESET_O), .BRIDGE_SEL_O(BRIDGE_SEL_O),
  .CONDUCTING_O(CONDUCTING_O)
);

// *** verification/armature_current_loop_tb.sv ***
// Purpose: self-checking bench for the armature current loop
// Assumes: APB slave with one wait cycle, standstill delay of 8
// Notes: ends through print_verdict
`timescale 1ns/1ps
module armature_current_loop_tb;
  // --------------------
  // signals and instances
  // --------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic signed [10:0] demand = 11'h000, feedback = 11'h000;
  logic signed [10:0] speed = 11'h1F4, ramp_ref = 11'h064;
  logic stop = 1'b0, discont = 1'b0, oc = 1'b0, breq = 1'b0;
  logic tune = 1'b0, ctune = 1'b0, creq = 1'b0;
  logic [1:0] quad = 2'h0;
  logic [7:0] tprop = 8'h00, tint = 8'h00, tmc = 8'h00, cprop = 8'h00;
  logic pready, pslverr, fire, dfire, rres, bsel, cond, pcond;
  logic [9:0] angle;
  logic [7:0] range_err;
  int error_cnt = 0, num_checks = 0;
  always #50 clk = ~clk;
  armature_current_loop #(.STANDSTILL_DELAY(8)) armature_current_loop_inst (
    .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .DEMAND_I(demand),
    .FEEDBACK_I(feedback), .SPEED_I(speed), .RAMP_REF_I(ramp_ref),
    .STOP_I(stop), .DISCONT_I(discont), .OVERCURRENT_I(oc),
    .BRIDGE_REQ_I(breq), .BRIDGE2_QUAD_I(quad),
    .PARTNER_CONDUCTING_I(pcond), .TUNE_LOAD_I(tune), .TUNE_PROP_I(tprop),
    .TUNE_INT_I(tint), .TUNE_MC_I(tmc), .CTUNE_LOAD_I(ctune),
    .CTUNE_PROP_I(cprop), .FIRING_ANGLE_O(angle), .FIRE_EN_O(fire),
    .DELAYED_FIRE_EN_O(dfire), .RAMP_RESET_O(rres), .BRIDGE_SEL_O(bsel),
    .CONDUCTING_O(cond));
  firing_partner_model #(.LAT(3)) firing_partner_model_inst (
    .clk_i(clk), .rst_i(rst), .fire_en_i(cond), .angle_i(angle),
    .conduct_req_i(creq), .conducting_o(pcond), .range_err_o(range_err));
  // --------------------
  // tasks
  // --------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chb(input string nm, input logic seen, exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20) chk("pready", 32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    print_verdict;
  end
  // --------------------
  // tests
  // --------------------
  initial begin
    int i;
    cyc(2);
    rst <= 1'b0;
    rdc("prop", 8'h00, 32'h10);
    rdc("integ", 8'h04, 32'h10);
    rdc("mconst", 8'h08, 32'h32);
    rdc("ctrl", 8'h10, 32'h2);
    for (i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'hFF);
      rdc("gain", 8'(4 * i), 32'hFF);
    end
    wr(8'h0C, 32'h5A);
    rdc("rsvd", 8'h0C, 32'h0);
    rdc("unmapped", 8'h1C, 32'h0);
    chb("slverr", err, 1'b1);
    $display("test registers done");
    tprop <= 8'h21;
    tint <= 8'h42;
    tmc <= 8'h63;
    tune <= 1'b1;
    @(posedge clk);
    tune <= 1'b0;
    rdc("tprop", 8'h00, 32'h21);
    rdc("tint", 8'h04, 32'h42);
    rdc("tmc", 8'h08, 32'h63);
    cprop <= 8'h07;
    ctune <= 1'b1;
    @(posedge clk);
    ctune <= 1'b0;
    rdc("cprop", 8'h00, 32'h07);
    rdc("cint", 8'h04, 32'h42);
    $display("test autotune done");
    wr(8'h10, 32'h3);
    cyc(3);
    chb("rres", rres, 1'b1);
    chb("fire", fire, 1'b0);
    wr(8'h10, 32'h2);
    cyc(3);
    chb("fire", fire, 1'b1);
    $display("test inhibit done");
    wr(8'h10, 32'hA);
    for (i = 0; i < 3; i++) begin
      ramp_ref <= (i == 0) ? 11'h064 : (i == 1) ? 11'h7C0 : 11'h3FF;
      cyc(4);
      chk("direct", {22'h0, angle}, (i == 0) ? 32'h179 :
        (i == 1) ? 32'h115 : 32'h3FF);
    end
    oc <= 1'b1;
    @(posedge clk);
    oc <= 1'b0;
    cyc(4);
    chb("trip", fire, 1'b0);
    rdc("status", 8'h14, 32'h1);
    wr(8'h14, 32'h1);
    cyc(3);
    rdc("status", 8'h14, 32'h4);
    $display("test direct done");
    wr(8'h10, 32'h2);
    speed <= 11'h005;
    ramp_ref <= 11'h000;
    cyc(3);
    chk("phase", {22'h0, angle}, 32'h115);
    cyc(12);
    chb("stopped", fire, 1'b0);
    wr(8'h10, 32'h6);
    cyc(3);
    chb("zero ref", fire, 1'b1);
    stop <= 1'b1;
    cyc(15);
    chb("stop", fire, 1'b0);
    speed <= 11'h008;
    cyc(3);
    chb("speed8", fire, 1'b1);
    stop <= 1'b0;
    speed <= 11'h1F4;
    $display("test standstill done");
    wr(8'h10, 32'h2);
    for (i = 1; i < 4; i++) begin
      quad <= 2'(i);
      wr(8'h10, 32'h42);
      rdc("sq12 refused", 8'h10, 32'h2);
      chb("dfire off", dfire, 1'b0);
    end
    quad <= 2'h0;
    wr(8'h10, 32'h42);
    rdc("sq12", 8'h10, 32'h42);
    cyc(3);
    chb("dfire", dfire, 1'b1);
    $display("test twelve done");
    wr(8'h10, 32'h12);
    creq <= 1'b1;
    cyc(8);
    breq <= 1'b1;
    cyc(8);
    chb("locked", bsel, 1'b0);
    creq <= 1'b0;
    cyc(10);
    chb("released", bsel, 1'b1);
    $display("test lockout done");
    wr(8'h10, 32'h2);
    demand <= 11'h064;
    feedback <= 11'h064;
    discont <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(8'h08, i ? 32'h20 : 32'h40);
      cyc(4);
      chk("adapt", {22'h0, angle}, i ? 32'h147 : 32'h179);
    end
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h80);
    discont <= 1'b0;
    feedback <= 11'h000;
    cyc(4);
    chk("prop", {22'h0, angle}, 32'h2BC);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h80);
    cyc(4);
    rd = {22'h0, angle};
    cyc(4);
    chk("integ", {22'h0, angle} - rd, 32'h64);
    chk("range", {24'h0, range_err}, 32'h0);
    $display("test adaptive done");
    print_verdict;
  end
endmodule

// *** verification/firing_partner_model.sv ***
// Purpose: partner drive and pulse generator stand-in
// Assumes: conduction follows the bench request after LAT cycles
// Notes: counts firing angles below minimum while firing
`timescale 1ns/1ps
module firing_partner_model #(
  parameter LAT = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire fire_en_i,
  input wire [9:0] angle_i,
  input wire conduct_req_i,
  output wire conducting_o,
  output reg [7:0] range_err_o
);
  // --------------------
  // conduction and range
  // --------------------
  reg [7:0] dly_reg;
  assign conducting_o = dly_reg[LAT-1];
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_reg <= 8'h00;
      range_err_o <= 8'h00;
    end else begin
      dly_reg <= {dly_reg[6:0], conduct_req_i};
      if (fire_en_i && angle_i < 10'h115)
        range_err_o <= range_err_o + 8'h01;
    end
  end
endmodule
